// File: rtl/epl_pkg.sv
// Constants, register map and carrier types of the egress profile and
// source address limiter.
// Assumes a single 100 MHz clock shared by every user of this package.
package epl_pkg;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_EP_CIR = 8'h04;
    localparam logic [7:0] REG_EP_CEIL = 8'h08;
    localparam logic [7:0] REG_EP_ER = 8'h0C;
    localparam logic [7:0] REG_SA_MAX = 8'h10;
    localparam logic [7:0] REG_SA_AGE = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_COS_LIST = 8'h1C;
    localparam logic [7:0] REG_SA_DROPS = 8'h20;
    localparam logic [1:0] REG_CLS_PAGE = 2'h1;
    localparam logic [1:0] CLS_F_NAME = 2'h0;
    localparam logic [1:0] CLS_F_CIR = 2'h1;
    localparam logic [1:0] CLS_F_CEIL = 2'h2;
    localparam logic [1:0] CLS_F_ER = 2'h3;
    localparam int CTRL_EP_EN = 0;
    localparam int CTRL_CLS_EN = 1;
    localparam int CTRL_SA_EN = 2;
    localparam int CLS_EN_BIT = 8;
    localparam int ER_TOP_LSB = 0;
    localparam int ER_RANK_LSB = 4;
    localparam int ER_ENV_LSB = 8;
    localparam int ER_NFLOW_LSB = 16;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] RATE_RST = 16'h0000;
    localparam logic [23:0] ER_RST = 24'h010000;
    localparam logic [15:0] SA_MAX_RST = 16'h0001;
    localparam logic [31:0] SA_AGE_RST = 32'h11E1A300;
    localparam logic [7:0] COS_LIST_RST = 8'h7F;
    localparam logic [2:0] COS_DISCARD = 3'h7;
    localparam logic [23:0] BURST_BYTES = 24'h002000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [47:0] mac;
        logic [15:0] len;
        logic [2:0] cos;
        logic yellow;
    } epl_frm_s;

    typedef enum logic [2:0] {
        EGR_IDLE = 3'b001,
        EGR_WAIT = 3'b010,
        EGR_SEND = 3'b100
    } epl_egr_e;
endpackage

// File: rtl/epl_top.sv
// Egress rate-profile shaper and ingress source address limiter of one
// connection endpoint, with its register port and egress frame FIFO.
// Assumes frame descriptors and register strobes synchronous to i_clock.
//
// Overview of operation
// RULE1: Endpoint egress profile is off or committed rate, ceiling, envelope and rank.
// RULE2: Enabled endpoint profile delays egress frames so none would be marked red.
// RULE3: Enabled class entry delays its class's frames so none would be red.
// RULE4: Endpoint single-flow envelope requires ceiling equal to committed rate.
// RULE5: Endpoint rank below envelope's highest requires committed rate zero.
// RULE6: Class entry single-flow envelope requires ceiling equal to committed rate.
// RULE7: Class entry rank below envelope's highest requires committed rate zero.
// RULE8: Each class name appears at most once among class entries.
// RULE9: Class entries never name the discard class, only listed connection classes.
// RULE10: Shaping uses ingress colour, and ingress class for class entries.
// RULE11: Address limit is off or a count of at least one with aging time.
// RULE12: Keep at most the count of addresses, aging unseen ones out.
// RULE13: Drop a frame with a new address while the list is full.
// RULE14: Each entry holds the latest arrival time of its address.
// RULE15: Entries are removed once timestamp plus aging time is reached.
// RULE16: With the limit off, no frame is dropped for its source address.
// RULE17: List is empty after reset and on enable; only unicast addresses enter.
// RULE18: Aged entries are absent; known refresh, unknown insert or drop.
`timescale 1ns/100ps
`default_nettype none

module epl_fifo #(
    parameter int WIDTH = 68,
    parameter int DEPTH = 16
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic rdy_q;
    wire push = i_valid & rdy_q;
    wire pop = o_valid & i_ready;

    assign o_valid = cnt_q != '0;
    assign o_data = mem_q[rd_q];
    assign o_ready = rdy_q;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_d;
            rdy_q <= cnt_d != (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end
endmodule

module epl_top #(
    parameter int NCLS = 4,
    parameter int NSA = 8,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire epl_pkg::epl_frm_s i_ing,
    input wire logic i_ing_valid,
    output logic o_ing_ready,
    output logic o_ing_done,
    output logic o_ing_drop,
    input wire epl_pkg::epl_frm_s i_egr,
    input wire logic i_egr_valid,
    output logic o_egr_ready,
    output epl_pkg::epl_frm_s o_egr,
    output logic o_egr_valid,
    input wire logic i_egr_ready
);
    localparam int SIW = $clog2(NSA);
    localparam int FW = $bits(epl_pkg::epl_frm_s);

    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // A rate is bytes per microsecond tick; ER packs top rank, rank, envelope, flow count.
    function automatic logic er_ok(input logic [15:0] committed_rate, input logic [15:0] ceil,
                                   input logic [23:0] er);
        logic single;
        logic top;
        single = er[epl_pkg::ER_NFLOW_LSB +: 8] == 8'h01;
        top = er[epl_pkg::ER_RANK_LSB +: 4] == er[epl_pkg::ER_TOP_LSB +: 4];
        er_ok = (!single || ceil == committed_rate) && (top || committed_rate == 16'h0000);
    endfunction

    function automatic logic [23:0] fill(input logic [23:0] b, input logic [15:0] r);
        logic [24:0] s;
        s = {1'b0, b} + {9'h000, r};
        fill = (s > {1'b0, epl_pkg::BURST_BYTES}) ? epl_pkg::BURST_BYTES : s[23:0];
    endfunction

    // Register file.
    logic [2:0] ctrl_q;
    logic [15:0] ep_cir_q;
    logic [15:0] ep_ceil_q;
    logic [23:0] ep_er_q;
    logic [15:0] sa_max_q;
    logic [31:0] sa_age_q;
    logic [7:0] cos_list_q;
    logic [31:0] sa_drops_q;
    logic [2:0] cls_name_q [NCLS];
    logic cls_en_q [NCLS];
    logic [15:0] cls_cir_q [NCLS];
    logic [15:0] cls_ceil_q [NCLS];
    logic [23:0] cls_er_q [NCLS];

    wire wr_top = i_wr && i_addr[7:6] == 2'h0;
    wire [1:0] cls_fld = i_addr[3:2];
    wire [1:0] cls_idx = i_addr[5:4];
    wire cls_hit = i_addr[7:6] == epl_pkg::REG_CLS_PAGE && 32'(cls_idx) < NCLS;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= epl_pkg::CTRL_RST;
            ep_cir_q <= epl_pkg::RATE_RST;
            ep_ceil_q <= epl_pkg::RATE_RST;
            ep_er_q <= epl_pkg::ER_RST;
            sa_max_q <= epl_pkg::SA_MAX_RST;
            sa_age_q <= epl_pkg::SA_AGE_RST;
            cos_list_q <= epl_pkg::COS_LIST_RST;
        end else if (wr_top) begin
            case (i_addr)
                epl_pkg::REG_CTRL: ctrl_q <= i_wdata[2:0];
                epl_pkg::REG_EP_CIR: ep_cir_q <= i_wdata[15:0];
                epl_pkg::REG_EP_CEIL: ep_ceil_q <= i_wdata[15:0];
                epl_pkg::REG_EP_ER: ep_er_q <= i_wdata[23:0];
                epl_pkg::REG_SA_MAX: sa_max_q <= i_wdata[15:0];
                epl_pkg::REG_SA_AGE: sa_age_q <= i_wdata;
                epl_pkg::REG_COS_LIST: cos_list_q <= i_wdata[7:0];
                default: ;
            endcase
        end
    end

    // Egress profile checks. A profile whose parameters break a constraint is
    // left unapplied and flagged, so a bad setting can never starve the port.
    wire ep_ok = er_ok(ep_cir_q, ep_ceil_q, ep_er_q); // RULE4 RULE5
    wire ep_act = ctrl_q[epl_pkg::CTRL_EP_EN] && ep_ok; // RULE1
    logic [NCLS-1:0] cls_dup;
    logic [NCLS-1:0] cls_bad;
    logic [NCLS-1:0] cls_act;

    always_comb begin
        cls_dup = '0;
        for (int i = 0; i < NCLS; i++) begin
            for (int j = 0; j < NCLS; j++) begin
                if (i != j && cls_en_q[i] && cls_en_q[j] && cls_name_q[i] == cls_name_q[j]) begin
                    cls_dup[i] = 1'b1; // RULE8
                end
            end
        end
    end

    // Egress datapath signals.
    epl_pkg::epl_frm_s head;
    logic head_valid;
    logic fifo_pop;
    logic tick_q;
    logic [6:0] tick_cnt_q;
    logic [31:0] now_q;
    logic [NCLS-1:0] cls_fit;
    logic [NCLS-1:0] cls_need;
    logic [23:0] cls_g_q [NCLS];
    logic [23:0] cls_y_q [NCLS];
    logic [23:0] ep_g_q;
    logic [23:0] ep_y_q;
    epl_pkg::epl_egr_e egr_q;
    wire [23:0] head_len = {8'h00, head.len};

    genvar gc;
    generate
        for (gc = 0; gc < NCLS; gc++) begin : g_cls
            assign cls_bad[gc] = cls_en_q[gc] && (cls_dup[gc]
                || !er_ok(cls_cir_q[gc], cls_ceil_q[gc], cls_er_q[gc]) // RULE6 RULE7
                || cls_name_q[gc] == epl_pkg::COS_DISCARD // RULE9
                || !cos_list_q[cls_name_q[gc]]); // RULE9
            assign cls_act[gc] = ctrl_q[epl_pkg::CTRL_CLS_EN] && cls_en_q[gc] && !cls_bad[gc];
            // The class match uses the class assigned at ingress, carried in the descriptor.
            assign cls_need[gc] = cls_act[gc] && head.cos == cls_name_q[gc]; // RULE10
            assign cls_fit[gc] = !cls_need[gc]
                || (head.yellow ? cls_y_q[gc] >= head_len : cls_g_q[gc] >= head_len); // RULE3

            always_ff @(posedge i_clock or negedge rst_n) begin
                if (!rst_n) begin
                    cls_name_q[gc] <= 3'h0;
                    cls_en_q[gc] <= 1'b0;
                    cls_cir_q[gc] <= epl_pkg::RATE_RST;
                    cls_ceil_q[gc] <= epl_pkg::RATE_RST;
                    cls_er_q[gc] <= epl_pkg::ER_RST;
                end else if (i_wr && cls_hit && 32'(cls_idx) == gc) begin
                    case (cls_fld)
                        epl_pkg::CLS_F_NAME: begin
                            cls_name_q[gc] <= i_wdata[2:0];
                            cls_en_q[gc] <= i_wdata[epl_pkg::CLS_EN_BIT];
                        end
                        epl_pkg::CLS_F_CIR: cls_cir_q[gc] <= i_wdata[15:0];
                        epl_pkg::CLS_F_CEIL: cls_ceil_q[gc] <= i_wdata[15:0];
                        default: cls_er_q[gc] <= i_wdata[23:0];
                    endcase
                end
            end

            // Green frames draw on the committed bucket, yellow on the ceiling bucket.
            always_ff @(posedge i_clock or negedge rst_n) begin
                if (!rst_n) begin
                    cls_g_q[gc] <= epl_pkg::BURST_BYTES;
                    cls_y_q[gc] <= epl_pkg::BURST_BYTES;
                end else begin
                    cls_g_q[gc] <= fill(cls_g_q[gc] - ((fifo_pop && cls_need[gc] && !head.yellow)
                        ? head_len : 24'h000000), tick_q ? cls_cir_q[gc] : 16'h0000);
                    cls_y_q[gc] <= fill(cls_y_q[gc] - ((fifo_pop && cls_need[gc] && head.yellow)
                        ? head_len : 24'h000000), tick_q ? cls_ceil_q[gc] : 16'h0000);
                end
            end
        end
    endgenerate

    // Microsecond time base for refill and address aging.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 7'h00;
            tick_q <= 1'b0;
            now_q <= 32'h00000000;
        end else begin
            tick_q <= tick_cnt_q == 7'(epl_pkg::TICK_CYC - 1);
            tick_cnt_q <= (tick_cnt_q == 7'(epl_pkg::TICK_CYC - 1)) ? 7'h00 : tick_cnt_q + 7'h01;
            now_q <= tick_q ? now_q + 32'h00000001 : now_q;
        end
    end

    // Frames are only ever held back until tokens suffice, never marked down or dropped.
    wire ep_fit = !ep_act || (head.yellow ? ep_y_q >= head_len : ep_g_q >= head_len); // RULE2
    wire fits = ep_fit && (&cls_fit);
    assign fifo_pop = egr_q == epl_pkg::EGR_WAIT && head_valid && fits;

    epl_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_data(i_egr),
        .i_valid(i_egr_valid),
        .o_ready(o_egr_ready),
        .o_data(head),
        .o_valid(head_valid),
        .i_ready(fifo_pop)
    );

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ep_g_q <= epl_pkg::BURST_BYTES;
            ep_y_q <= epl_pkg::BURST_BYTES;
        end else begin
            ep_g_q <= fill(ep_g_q - ((fifo_pop && ep_act && !head.yellow) ? head_len : 24'h000000),
                tick_q ? ep_cir_q : 16'h0000); // RULE10
            ep_y_q <= fill(ep_y_q - ((fifo_pop && ep_act && head.yellow) ? head_len : 24'h000000),
                tick_q ? ep_ceil_q : 16'h0000);
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            egr_q <= epl_pkg::EGR_IDLE;
            o_egr <= '0;
            o_egr_valid <= 1'b0;
        end else begin
            case (egr_q)
                epl_pkg::EGR_IDLE: begin
                    if (head_valid) begin
                        egr_q <= epl_pkg::EGR_WAIT;
                    end
                end
                epl_pkg::EGR_WAIT: begin
                    if (fifo_pop) begin
                        o_egr <= head;
                        o_egr_valid <= 1'b1;
                        egr_q <= epl_pkg::EGR_SEND;
                    end
                end
                epl_pkg::EGR_SEND: begin
                    if (i_egr_ready) begin
                        o_egr_valid <= 1'b0;
                        egr_q <= epl_pkg::EGR_IDLE;
                    end
                end
                default: egr_q <= epl_pkg::EGR_IDLE;
            endcase
        end
    end

    // Source address limiter.
    logic sa_v_q [NSA];
    logic [47:0] sa_mac_q [NSA];
    logic [31:0] sa_ts_q [NSA];
    logic [NSA-1:0] sa_live;
    logic [NSA-1:0] sa_match;
    logic [SIW:0] live_cnt;
    logic [SIW-1:0] free_idx;
    wire sa_cfg_ok = sa_max_q != 16'h0000; // RULE11
    wire sa_act = ctrl_q[epl_pkg::CTRL_SA_EN] && sa_cfg_ok;
    wire [15:0] sa_cap = (32'(sa_max_q) > NSA) ? 16'(NSA) : sa_max_q;
    wire arrive = i_ing_valid && o_ing_ready;
    wire unicast = !i_ing.mac[40]; // RULE17
    wire sa_hit = |sa_match;
    wire sa_full = 16'(live_cnt) >= sa_cap; // RULE12
    wire sa_new = arrive && sa_act && unicast && !sa_hit;
    wire sa_drop = sa_new && sa_full; // RULE13 RULE16
    wire sa_ins = sa_new && !sa_full; // RULE18

    always_comb begin
        live_cnt = '0;
        free_idx = '0;
        for (int k = NSA - 1; k >= 0; k--) begin
            live_cnt = live_cnt + (SIW+1)'(sa_live[k]);
            if (!sa_live[k]) begin
                free_idx = SIW'(k);
            end
        end
    end

    genvar gs;
    generate
        for (gs = 0; gs < NSA; gs++) begin : g_sa
            wire [31:0] age = now_q - sa_ts_q[gs];
            assign sa_live[gs] = sa_v_q[gs] && age < sa_age_q; // RULE18
            assign sa_match[gs] = sa_live[gs] && sa_mac_q[gs] == i_ing.mac;

            always_ff @(posedge i_clock or negedge rst_n) begin
                if (!rst_n) begin
                    sa_v_q[gs] <= 1'b0;
                    sa_mac_q[gs] <= 48'h000000000000;
                    sa_ts_q[gs] <= 32'h00000000;
                end else if (!sa_act) begin
                    sa_v_q[gs] <= 1'b0; // RULE17
                end else if (sa_ins && free_idx == SIW'(gs)) begin
                    sa_v_q[gs] <= 1'b1;
                    sa_mac_q[gs] <= i_ing.mac;
                    sa_ts_q[gs] <= now_q;
                end else if (arrive && sa_match[gs]) begin
                    sa_ts_q[gs] <= now_q; // RULE14
                end else if (!sa_live[gs]) begin
                    sa_v_q[gs] <= 1'b0; // RULE15
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_ing_ready <= 1'b0;
            o_ing_done <= 1'b0;
            o_ing_drop <= 1'b0;
            sa_drops_q <= 32'h00000000;
        end else begin
            o_ing_ready <= 1'b1;
            o_ing_done <= arrive;
            o_ing_drop <= sa_drop;
            sa_drops_q <= sa_drops_q + 32'(sa_drop);
        end
    end

    // Register read, answered in the following cycle only.
    logic [31:0] rd_cls;
    logic [31:0] rd_mux;
    wire [31:0] status = (32'(live_cnt) << 16) | (32'(cls_bad) << 8)
        | {28'h0000000, sa_full, sa_cfg_ok, ~|cls_bad, ep_ok};
    always_comb begin
        rd_cls = 32'h00000000;
        for (int i = 0; i < NCLS; i++) begin
            if (32'(cls_idx) == i) begin
                case (cls_fld)
                    epl_pkg::CLS_F_NAME: rd_cls = {23'h000000, cls_en_q[i], 5'h00, cls_name_q[i]};
                    epl_pkg::CLS_F_CIR: rd_cls = {16'h0000, cls_cir_q[i]};
                    epl_pkg::CLS_F_CEIL: rd_cls = {16'h0000, cls_ceil_q[i]};
                    default: rd_cls = {8'h00, cls_er_q[i]};
                endcase
            end
        end
    end
    always_comb begin
        case (i_addr)
            epl_pkg::REG_CTRL: rd_mux = {29'h00000000, ctrl_q};
            epl_pkg::REG_EP_CIR: rd_mux = {16'h0000, ep_cir_q};
            epl_pkg::REG_EP_CEIL: rd_mux = {16'h0000, ep_ceil_q};
            epl_pkg::REG_EP_ER: rd_mux = {8'h00, ep_er_q};
            epl_pkg::REG_SA_MAX: rd_mux = {16'h0000, sa_max_q};
            epl_pkg::REG_SA_AGE: rd_mux = sa_age_q;
            epl_pkg::REG_STATUS: rd_mux = status;
            epl_pkg::REG_COS_LIST: rd_mux = {24'h000000, cos_list_q};
            epl_pkg::REG_SA_DROPS: rd_mux = sa_drops_q;
            default: rd_mux = cls_hit ? rd_cls : 32'h00000000;
        endcase
    end
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= i_rd ? rd_mux : 32'h00000000;
        end
    end

    property p_ep_no_red;
        @(posedge i_clock) disable iff (!rst_n)
        fifo_pop && ep_act |-> (head.yellow ? ep_y_q >= head_len : ep_g_q >= head_len);
    endproperty
    a_ep_no_red: assert property (p_ep_no_red) else $error("Endpoint frame sent short of tokens."); // RULE2

    property p_cls_no_red;
        @(posedge i_clock) disable iff (!rst_n)
        fifo_pop |-> &cls_fit;
    endproperty
    a_cls_no_red: assert property (p_cls_no_red) else $error("Class frame sent short of tokens."); // RULE3

    localparam int ER_NFLOW_LSB_C = epl_pkg::ER_NFLOW_LSB;
    property p_ep_bad_off;
        @(posedge i_clock) disable iff (!rst_n)
        ep_er_q[ER_NFLOW_LSB_C +: 8] == 8'h01 && ep_ceil_q != ep_cir_q |-> !ep_act;
    endproperty
    a_ep_bad_off: assert property (p_ep_bad_off) else $error("Bad endpoint profile applied."); // RULE4

    property p_dup_off;
        @(posedge i_clock) disable iff (!rst_n)
        |cls_dup |-> (cls_act & cls_dup) == '0;
    endproperty
    a_dup_off: assert property (p_dup_off) else $error("Duplicate class entry active."); // RULE8

    property p_colour_kept;
        @(posedge i_clock) disable iff (!rst_n)
        fifo_pop |=> o_egr_valid && o_egr.yellow == $past(head.yellow) && o_egr.cos == $past(head.cos);
    endproperty
    a_colour_kept: assert property (p_colour_kept) else $error("Egress colour or class altered."); // RULE10

    property p_sa_off_nodrop;
        @(posedge i_clock) disable iff (!rst_n)
        !sa_act |=> !o_ing_drop;
    endproperty
    a_sa_off_nodrop: assert property (p_sa_off_nodrop) else $error("Drop with limit off."); // RULE16

    property p_full_drop;
        @(posedge i_clock) disable iff (!rst_n)
        arrive && sa_act && unicast && !sa_hit && sa_full |=> o_ing_drop && o_ing_done;
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("New address not dropped when full."); // RULE13

    property p_bounded;
        @(posedge i_clock) disable iff (!rst_n)
        sa_act |-> 16'(live_cnt) <= sa_cap;
    endproperty
    a_bounded: assert property (p_bounded) else $error("Address list exceeds limit."); // RULE12

    property p_empty_on_enable;
        @(posedge i_clock) disable iff (!rst_n)
        $rose(sa_act) |-> live_cnt == '0;
    endproperty
    a_empty_on_enable: assert property (p_empty_on_enable) else $error("List not empty on enable."); // RULE17
endmodule

`default_nettype wire

// File: tb/epl_sub_model.sv
// Subscriber side model that presents one ingress descriptor per request.
// Assumes the bench drives i_send and i_mac just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module epl_sub_model (
    input wire logic i_clock,
    input wire logic i_send,
    input wire logic [47:0] i_mac,
    output epl_pkg::epl_frm_s o_ing,
    output logic o_ing_valid
);
    epl_pkg::epl_frm_s frm;
    epl_pkg::epl_frm_s last_q;
    assign frm = {i_mac, 16'h0040, 3'h0, 1'b0};
    // An idle bus shows the inverse of the last frame, so a stale address never looks valid.
    always_ff @(posedge i_clock) begin
        if (i_send) begin
            last_q <= frm;
        end
    end
    assign o_ing = i_send ? frm : ~last_q;
    assign o_ing_valid = i_send;
endmodule
`default_nettype wire

// File: tb/test_epl_top.sv
// Self-checking bench of the egress shaper and source address limiter.
// Assumes the subscriber model on ingress and an egress sink that is ready except while one released class frame is held.
`timescale 1ns/100ps
`default_nettype none
module test_epl_top;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, send = 1'b0, ev = 1'b0, er = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [47:0] mac = 48'h0;
    epl_pkg::epl_frm_s ing, eo, egr = '0;
    logic ivld, irdy, done, drop, erdy, eov;
    int n_mismatch = 0, tests_run = 0;
    logic [31:0] rows [9][2] = '{'{32'h00, 32'h0}, '{32'h04, 32'h0}, '{32'h08, 32'h0},
        '{32'h0C, 32'h10000}, '{32'h10, 32'h1}, '{32'h14, 32'h11E1A300},
        '{32'h1C, 32'h7F}, '{32'h20, 32'h0}, '{32'h3C, 32'h0}};
    always #5 clk = ~clk;
    epl_sub_model i_epl_sub_model(.i_clock(clk), .i_send(send), .i_mac(mac), .o_ing(ing),
        .o_ing_valid(ivld));
    epl_top i_epl_top(.i_clock(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdat), .i_ing(ing), .i_ing_valid(ivld), .o_ing_ready(irdy),
        .o_ing_done(done), .o_ing_drop(drop), .i_egr(egr), .i_egr_valid(ev),
        .o_egr_ready(erdy), .o_egr(eo), .o_egr_valid(eov), .i_egr_ready(er));
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wrr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask
    task automatic ingr(input logic [47:0] m, input logic x);
        @(posedge clk);
        mac <= m;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        #1 cmp("ingress done", 32'h1, {31'h0, done});
        cmp("ingress drop", {31'h0, x}, {31'h0, drop});
        cmp("ingress ready", 32'h1, {31'h0, irdy});
    endtask
    // A frame that must never leave is watched far longer than one that must.
    task automatic egrr(input logic [15:0] len, input logic [47:0] m, input logic x);
        int k;
        @(posedge clk);
        egr <= {m, len, 3'h1, 1'b1};
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
        #1;
        cmp("egress ready", 32'h1, {31'h0, erdy});
        for (k = 0; k < (x ? 30 : 300) && eov !== 1'b1; k++) @(posedge clk) #1;
        cmp("egress valid", {31'h0, x}, {31'h0, eov});
        if (x) cmp("egress mac", m[31:0], eo.mac[31:0]);
        if (x) cmp("egress colour", 32'h3, {28'h0, eo.cos, eo.yellow});
        if (x && eov !== 1'b1) report_and_stop();
    endtask
    initial begin
        repeat (16) @(posedge clk);
        cmp("ready in reset", 32'h0, {31'h0, irdy});
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            rdr(rows[i][0][7:0]);
            cmp("register", rows[i][1], d);
        end
        ingr(48'h1, 1'b0);
        ingr(48'h2, 1'b0);
        wrr(epl_pkg::REG_SA_MAX, 32'h2);
        wrr(epl_pkg::REG_SA_AGE, 32'h4);
        wrr(epl_pkg::REG_CTRL, 32'h4);
        ingr(48'hA, 1'b0);
        ingr(48'hB, 1'b0);
        ingr(48'hC, 1'b1);
        ingr(48'h0100_0000_000C, 1'b0);
        repeat (250) @(posedge clk);
        ingr(48'hA, 1'b0);
        repeat (250) @(posedge clk);
        ingr(48'hC, 1'b0);
        ingr(48'hA, 1'b0);
        ingr(48'hD, 1'b1);
        rdr(epl_pkg::REG_SA_DROPS);
        cmp("drop count", 32'h2, d);
        rdr(epl_pkg::REG_STATUS);
        cmp("live and full", 32'h5, {23'h0, d[23:16], d[3]});
        wrr(epl_pkg::REG_EP_CEIL, 32'h10);
        rdr(epl_pkg::REG_STATUS);
        cmp("endpoint ok", 32'h0, {31'h0, d[0]});
        wrr(epl_pkg::REG_EP_ER, 32'h0002_0012);
        wrr(epl_pkg::REG_EP_CIR, 32'h10);
        rdr(epl_pkg::REG_STATUS);
        cmp("endpoint ok", 32'h0, {31'h0, d[0]});
        wrr(epl_pkg::REG_EP_ER, 32'h0001_0000);
        wrr(8'h40, 32'h0000_0107);
        rdr(epl_pkg::REG_STATUS);
        cmp("class flags", 32'h5, {29'h0, d[8], d[1], d[0]});
        wrr(8'h40, 32'h0000_0101);
        wrr(8'h50, 32'h0000_0101);
        rdr(epl_pkg::REG_STATUS);
        cmp("class ok", 32'h0, {31'h0, d[1]});
        wrr(8'h50, 32'h0);
        wrr(epl_pkg::REG_CTRL, 32'h1);
        egrr(16'h0040, 48'h11, 1'b1);
        wrr(epl_pkg::REG_CTRL, 32'h2);
        egrr(16'h2000, 48'h33, 1'b1);
        egrr(16'h0001, 48'h44, 1'b0);
        // Hold the sink so the released class frame stands until it is seen.
        @(posedge clk) er <= 1'b0;
        wrr(epl_pkg::REG_CTRL, 32'h1);
        egrr(16'h2001, 48'h44, 1'b1);
        @(posedge clk) er <= 1'b1;
        egrr(16'h0040, 48'h55, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
